// >>> rtl/bie_core.sv
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps

// Behaviour
// RULE1: far_jump reaches any address, no condition.
// RULE2: Target literal loads program counter bits 20..1.
// RULE3: Two words; counter written after second word.
// RULE4: far_jump takes two cycles, second is idle.
// RULE5: Increment opcode is 001010, then d, a, f.
// RULE6: Read register, add one, deliver sum.
// RULE7: d clear selects accumulator, set selects register.
// RULE8: a clear fast bank, set uses bank pointer.
// RULE9: Extended mode, a clear, f<=95 uses indexing.
// RULE10: Plain increment updates C, DC, N, OV, Z.
// RULE11: Skip-nonzero stores, skips on nonzero, flags kept.
// RULE12: Skip discards fetched word; two-word skip costs more.
// RULE13: Skip-zero stores, skips on zero, flags kept.
// RULE14: Read Q2, add Q3, write Q4.
module bie_core
  import bie_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program memory fetch path.
  output logic [PC_W-1:0] prog_addr,
  input wire logic [15:0] instr_data,
  // Data register file.
  output logic [RF_ADDR_W-1:0] rf_addr,
  output logic rf_re,
  input wire logic [7:0] rf_rdata,
  output logic [7:0] rf_wdata,
  output logic rf_we
);

  // Quarter-cycle sequencer and fetch pipeline.
  logic [1:0] qtr_q, qtr_d; // Current quarter of the instruction cycle.
  bie_state_t state_q, state_d; // What the current cycle does.
  logic [PC_W-1:0] pc_q, pc_d; // Address of the next word to fetch.
  logic [15:0] ir_q, ir_d; // Instruction being executed this cycle.
  logic ir_vld_q, ir_vld_d; // Low until the first fetch lands.
  logic [7:0] klo_q, klo_d; // Low target byte of a far jump.

  // Datapath state.
  logic [7:0] opnd_q, opnd_d; // Byte read from the register file.
  logic [7:0] res_q, res_d; // Incremented byte.
  logic [4:0] rflg_q, rflg_d; // Flags of the increment.
  logic [7:0] acc_q, acc_d; // Accumulator.
  logic [4:0] flg_q, flg_d; // Status flags.
  logic skip_q, skip_d; // Last increment-and-test took its skip.
  logic [RF_ADDR_W-1:0] rfa_q, rfa_d; // Register file address.
  logic rfre_q, rfre_d; // Read strobe during Q2.
  logic rfwe_q, rfwe_d; // Write strobe during Q4.

  // Software-visible control.
  logic run_q, run_d; // Core runs only while set.
  logic ext_q, ext_d; // Extended instruction set enable.
  logic [3:0] bsr_q, bsr_d; // bank_select_pointer.
  logic [RF_ADDR_W-1:0] idx_q, idx_d; // Base for indexed literal offset mode.
  logic [31:0] rdata_q, rdata_d; // Registered read data.
  logic err_q, err_d; // Registered error for the access phase.

  // Decode helpers.
  logic [5:0] opc; // Upper six bits of the instruction.
  logic is_inc, is_skz, is_sknz, is_jump, is_any_inc;
  logic [7:0] f_addr; // Register address field.
  logic [RF_ADDR_W-1:0] eff_addr; // Address after banking.
  logic [7:0] inc_sum;
  logic [4:0] inc_flg;
  logic apb_setup, apb_wr, mapped;

  // The incrementer is shared by all three increment forms.
  bie_incr u_incr (
    .opnd(opnd_q),
    .sum(inc_sum),
    .flags(inc_flg)
  );

  // Instruction decode from the executing word.
  always_comb begin
    opc = ir_q[15:10];
    f_addr = ir_q[7:0];
    is_inc = ir_vld_q & (opc == OPC_INC); // RULE5
    is_skz = ir_vld_q & (opc == OPC_INC_SKZ);
    is_sknz = ir_vld_q & (opc == OPC_INC_SKNZ);
    is_jump = ir_vld_q & (ir_q[15:8] == OPC_JUMP_W1);
    is_any_inc = is_inc | is_skz | is_sknz;
    // Banking choice; indexing wins over the fast bank in extended mode.
    if (!ir_q[BIT_BANK] && ext_q && (f_addr <= INDEX_LIMIT)) begin
      eff_addr = idx_q + {4'h0, f_addr}; // RULE9
    end else if (!ir_q[BIT_BANK]) begin
      // The fast bank splits between the bottom and the top of the space.
      eff_addr = (f_addr < ACCESS_SPLIT) ? {4'h0, f_addr} : {ACCESS_HI_BANK, f_addr}; // RULE8
    end else begin
      eff_addr = {bsr_q, f_addr}; // RULE8
    end
  end

  // Next-state logic of the sequencer and datapath.
  always_comb begin
    qtr_d = qtr_q;
    state_d = state_q;
    pc_d = pc_q;
    ir_d = ir_q;
    ir_vld_d = ir_vld_q;
    klo_d = klo_q;
    opnd_d = opnd_q;
    res_d = res_q;
    rflg_d = rflg_q;
    acc_d = acc_q;
    flg_d = flg_q;
    skip_d = skip_q;
    rfa_d = rfa_q;
    rfre_d = 1'b0;
    rfwe_d = 1'b0;
    if (run_q) begin
      qtr_d = qtr_q + 2'h1;
      case (qtr_q)
        QTR_1: begin
          // Decode; present the operand address for the read in Q2.
          if (state_q == ST_EXEC && is_any_inc) begin
            rfa_d = eff_addr;
            rfre_d = 1'b1; // RULE14
          end
        end
        QTR_2: begin
          // Capture the operand, or the low target byte of a far jump.
          if (state_q == ST_EXEC && is_any_inc) begin
            opnd_d = rf_rdata; // RULE6 RULE14
          end
          if (state_q == ST_EXEC && is_jump) begin
            klo_d = ir_q[7:0]; // RULE3
          end
        end
        QTR_3: begin
          // Add; a register destination gets its write strobe for Q4.
          if (state_q == ST_EXEC && is_any_inc) begin
            res_d = inc_sum; // RULE6 RULE14
            rflg_d = inc_flg;
            rfwe_d = ir_q[BIT_DEST]; // RULE7
          end
        end
        QTR_4: begin
          // Retire the instruction and fetch the next word.
          ir_d = instr_data;
          ir_vld_d = 1'b1;
          pc_d = pc_q + 21'h000002;
          state_d = ST_EXEC;
          case (state_q)
            ST_EXEC: begin
              if (is_any_inc) begin
                if (!ir_q[BIT_DEST]) begin
                  acc_d = res_q; // RULE7
                end
                if (is_inc) begin
                  flg_d = rflg_q; // RULE10
                end
                // Only the plain increment touches the flags.
                skip_d = (is_skz && res_q == 8'h00) || (is_sknz && res_q != 8'h00); // RULE11 RULE13
                if (skip_d) begin
                  state_d = ST_SKIP; // RULE12
                end
              end else if (is_jump) begin
                // The word fetched now is the second jump word, never executed.
                if (instr_data[15:12] == OPC_JUMP_W2) begin
                  pc_d = {instr_data[11:0], klo_q, 1'b0}; // RULE1 RULE2 RULE3
                end
                ir_vld_d = 1'b0;
                state_d = ST_JUMP2; // RULE4
              end
            end
            ST_SKIP: begin
              // A discarded two-word jump drags its second word into the idle run.
              if (is_jump) begin
                state_d = ST_SKIP; // RULE12
                ir_vld_d = 1'b1;
              end
            end
            ST_JUMP2: begin
              state_d = ST_EXEC; // RULE4
            end
            default: begin
              state_d = ST_EXEC;
            end
          endcase
        end
        default: begin
          qtr_d = QTR_1;
        end
      endcase
    end else begin
      qtr_d = QTR_1;
    end
    // Accumulator and flag writes land except in Q4 of a running core; program counter writes only while it is stopped.
    if (apb_wr && paddr == OFS_ACC && !(run_q && qtr_q == QTR_4)) begin
      acc_d = pwdata[7:0];
    end
    if (apb_wr && paddr == OFS_FLAGS && !(run_q && qtr_q == QTR_4)) begin
      flg_d = pwdata[FLG_N:FLG_C];
      skip_d = skip_d & ~pwdata[FLG_SKIP];
    end
    if (apb_wr && paddr == OFS_PC && !run_q) begin
      pc_d = {pwdata[PC_W-1:1], 1'b0};
      ir_vld_d = 1'b0;
    end
  end

  // Sequencer and datapath registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qtr_q <= QTR_1;
      state_q <= ST_EXEC;
      pc_q <= PC_RST;
      ir_q <= 16'h0000;
      ir_vld_q <= 1'b0;
      klo_q <= 8'h00;
      opnd_q <= 8'h00;
      res_q <= 8'h00;
      rflg_q <= FLG_RST;
      acc_q <= ACC_RST;
      flg_q <= FLG_RST;
      skip_q <= 1'b0;
      rfa_q <= {RF_ADDR_W{1'b0}};
      rfre_q <= 1'b0;
      rfwe_q <= 1'b0;
    end else begin
      qtr_q <= qtr_d;
      state_q <= state_d;
      pc_q <= pc_d;
      ir_q <= ir_d;
      ir_vld_q <= ir_vld_d;
      klo_q <= klo_d;
      opnd_q <= opnd_d;
      res_q <= res_d;
      rflg_q <= rflg_d;
      acc_q <= acc_d;
      flg_q <= flg_d;
      skip_q <= skip_d;
      rfa_q <= rfa_d;
      rfre_q <= rfre_d;
      rfwe_q <= rfwe_d;
    end
  end

  // APB decode; the slave never stretches a transfer.
  always_comb begin
    apb_setup = psel & ~penable;
    apb_wr = psel & penable & pwrite;
    mapped = (paddr == OFS_CTRL) || (paddr == OFS_INDEX) || (paddr == OFS_FLAGS) ||
             (paddr == OFS_ACC) || (paddr == OFS_PC);
  end

  // Control register next values and the read mux.
  always_comb begin
    run_d = run_q;
    ext_d = ext_q;
    bsr_d = bsr_q;
    idx_d = idx_q;
    rdata_d = rdata_q;
    err_d = err_q;
    if (apb_wr && paddr == OFS_CTRL) begin
      run_d = pwdata[CTRL_RUN];
      ext_d = pwdata[CTRL_EXT];
      bsr_d = pwdata[CTRL_BSR_LO +: 4];
    end
    if (apb_wr && paddr == OFS_INDEX) begin
      idx_d = pwdata[RF_ADDR_W-1:0];
    end
    // Read data is taken in the setup cycle so it comes from a flip-flop.
    if (apb_setup) begin
      err_d = ~mapped;
      case (paddr)
        OFS_CTRL: rdata_d = {20'h00000, bsr_q, 6'h00, ext_q, run_q};
        OFS_INDEX: rdata_d = {20'h00000, idx_q};
        OFS_FLAGS: rdata_d = {23'h000000, skip_q, 3'h0, flg_q};
        OFS_ACC: rdata_d = {24'h000000, acc_q};
        OFS_PC: rdata_d = {11'h000, pc_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // Control registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      ext_q <= 1'b0;
      bsr_q <= BSR_RST;
      idx_q <= INDEX_RST;
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end else begin
      run_q <= run_d;
      ext_q <= ext_d;
      bsr_q <= bsr_d;
      idx_q <= idx_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // Outputs.
  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_q;
  assign prog_addr = pc_q;
  assign rf_addr = rfa_q;
  assign rf_re = rfre_q;
  assign rf_wdata = res_q;
  assign rf_we = rfwe_q;

endmodule

// >>> rtl/bie_incr.sv
`timescale 1ns/100ps

// Adds one to a data byte and works out the arithmetic flags of that addition.
module bie_incr
  import bie_pkg::*;
(
  // Operand.
  input wire logic [7:0] opnd,
  // Result and flags.
  output logic [7:0] sum,
  output logic [4:0] flags
);

  logic [8:0] wide; // Sum with carry out of bit 7.
  logic [4:0] half; // Low nibble sum with carry into bit 4.

  // Pure combinational adder; the caller registers the outputs.
  always_comb begin
    wide = {1'b0, opnd} + 9'h001;
    half = {1'b0, opnd[3:0]} + 5'h01;
    sum = wide[7:0];
    flags = 5'h00;
    flags[FLG_C] = wide[8];
    flags[FLG_DC] = half[4];
    flags[FLG_Z] = (wide[7:0] == 8'h00);
    // Only a positive operand can overflow when one is added.
    flags[FLG_OV] = ~opnd[7] & wide[7];
    flags[FLG_N] = wide[7];
  end

endmodule

// >>> rtl/bie_pkg.sv
package bie_pkg;

  // Geometry of the core datapath.
  localparam int PC_W = 21;
  localparam int RF_ADDR_W = 12;

  // Opcode fields, compared against the upper bits of an instruction word.
  localparam logic [5:0] OPC_INC = 6'h0a;
  localparam logic [5:0] OPC_INC_SKZ = 6'h0f;
  localparam logic [5:0] OPC_INC_SKNZ = 6'h12;
  localparam logic [7:0] OPC_JUMP_W1 = 8'hef;
  localparam logic [3:0] OPC_JUMP_W2 = 4'hf;

  // Instruction field positions.
  localparam int BIT_DEST = 9;
  localparam int BIT_BANK = 8;

  // Addresses below this value of the fast bank map to bank zero, the rest to the top bank.
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

  // Quarter-cycle numbering within one instruction cycle.
  localparam logic [1:0] QTR_1 = 2'h0;
  localparam logic [1:0] QTR_2 = 2'h1;
  localparam logic [1:0] QTR_3 = 2'h2;
  localparam logic [1:0] QTR_4 = 2'h3;

  // Register byte offsets on the APB.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INDEX = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_ACC = 8'h0c;
  localparam logic [7:0] OFS_PC = 8'h10;

  // Control register fields.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_BSR_LO = 8;

  // Flag register layout: carry, digit carry, zero, overflow, negative.
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  localparam int FLG_SKIP = 8;

  // Reset values.
  localparam logic [PC_W-1:0] PC_RST = 21'h000000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] FLG_RST = 5'h00;
  localparam logic [3:0] BSR_RST = 4'h0;
  localparam logic [RF_ADDR_W-1:0] INDEX_RST = 12'h000;

  // Execution state of the core.
  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_JUMP2 = 2'b01,
    ST_SKIP = 2'b10
  } bie_state_t;

endpackage

// >>> tb/bie_checker.sv
`timescale 1ns/100ps

// Watches fetch, register file and bus timing of the core.
module bie_checker
  import bie_pkg::*;
(
  // Clock, reset and bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Program and register file side.
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic [15:0] instr_data,
  input wire logic [RF_ADDR_W-1:0] rf_addr,
  input wire logic rf_re,
  input wire logic [7:0] rf_rdata,
  input wire logic [7:0] rf_wdata,
  input wire logic rf_we
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Fetch addresses stay on word boundaries.
  chk_pc_even: assert property (prog_addr[0] == 1'b0)
    else $error("odd fetch address");
  // One read strobe per instruction cycle, one quarter long.
  chk_read_pulse: assert property ($rose(rf_re) |=> !rf_re [*3])
    else $error("read strobe too long or too close");
  chk_write_slot: assert property (rf_we |-> $past(rf_re, 2))
    else $error("write not two quarters after read");
  // The written byte is the byte read plus one.
  chk_write_sum: assert property (rf_we |-> rf_wdata == $past(rf_rdata, 2) + 8'h01)
    else $error("written value is not read value plus one");
  chk_write_back: assert property (rf_we |-> rf_addr == $past(rf_addr, 2))
    else $error("write goes to another register");
  chk_addr_hold: assert property (rf_re |=> $stable(rf_addr) [*2])
    else $error("register address moved mid-instruction");
  chk_one_write: assert property (rf_we |=> !rf_we)
    else $error("write strobe longer than a quarter");
  // A new fetch address holds for a whole instruction cycle.
  chk_fetch_pace: assert property ($changed(prog_addr) |=> $stable(prog_addr) [*3])
    else $error("fetch address changed within a cycle");
  chk_no_wait: assert property (pready)
    else $error("bus answer delayed");
  chk_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
endmodule

bind bie_core bie_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .prog_addr, .instr_data, .rf_addr, .rf_re, .rf_rdata, .rf_wdata, .rf_we);

// >>> tb/bie_mem_model.sv
`timescale 1ns/100ps

// Program memory and data register file facing the core.
module bie_mem_model
  import bie_pkg::*;
(
  // Clock.
  input wire logic pclk,
  // Fetch path.
  input wire logic [PC_W-1:0] prog_addr,
  output logic [15:0] instr_data,
  // Register file.
  input wire logic [RF_ADDR_W-1:0] rf_addr,
  input wire logic rf_re,
  output logic [7:0] rf_rdata,
  input wire logic [7:0] rf_wdata,
  input wire logic rf_we
);
  // Contents are loaded by the bench while the core is stopped.
  // Both start cleared so that unloaded words decode as no operation.
  logic [15:0] pm [256] = '{default: 16'h0000};
  logic [7:0] rf [4096] = '{default: 8'h00};
  logic [7:0] last_q = 8'h00;

  assign instr_data = pm[prog_addr[8:1]];
  // Outside a strobe the lines show the inverse, so stale data cannot pass.
  assign rf_rdata = rf_re ? rf[rf_addr] : ~last_q;

  // Writes land at the edge that ends the write quarter.
  always @(posedge pclk) begin
    if (rf_re) last_q <= rf[rf_addr];
    if (rf_we) rf[rf_addr] <= rf_wdata;
  end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/100ps

// Self-checking bench for the increment and jump core.
module tb_top
  import bie_pkg::*;
();
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, rf_re, rf_we;
  logic seen = 1'b0;
  logic [PC_W-1:0] prog_addr, jt = '0;
  logic [15:0] instr_data;
  logic [RF_ADDR_W-1:0] rf_addr;
  logic [7:0] rf_rdata, rf_wdata;
  int bad_count = 0, num_checks = 0, cyc = 0;
  // Corner operands: wrap, overflow, nibble carry.
  logic [7:0] cv [6] = '{8'hff, 8'hff, 8'hff, 8'h7f, 8'h0f, 8'hfe};

  always #10 pclk = ~pclk;

  bie_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .prog_addr, .instr_data, .rf_addr, .rf_re, .rf_rdata, .rf_wdata, .rf_we);
  bie_mem_model i_mem (.pclk, .prog_addr, .instr_data, .rf_addr, .rf_re, .rf_rdata, .rf_wdata, .rf_we);

  // Notes whether a jump target was ever fetched.
  always @(posedge pclk) begin
    if (prog_addr === jt) seen <= 1'b1;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d bad=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      tally_and_finish;
    end
  end

  // One bus transfer; holds everything until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Flags of a plain increment: N, OV, Z, DC, C.
  function automatic logic [4:0] iflags(input logic [7:0] v);
    logic [7:0] s;
    s = v + 8'h01;
    return {s[7], v == 8'h7f, s == 8'h00, v[3:0] == 4'hf, v == 8'hff};
  endfunction

  // Runs the core from address zero for n instruction cycles, then stops it.
  task automatic run(input logic [31:0] ctrl, input int n);
    apb(1'b1, OFS_PC, 32'h0);
    apb(1'b1, OFS_CTRL, ctrl);
    repeat (n * 4) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h0);
    foreach (i_mem.pm[i]) i_mem.pm[i] = 16'h0000;
  endtask

  // One increment form, then a probe that only runs if nothing was skipped.
  task automatic inc_test(input int k, input logic [7:0] v);
    logic [5:0] op;
    logic d, a, x, skip;
    logic [3:0] b;
    logic [7:0] f, m0, s;
    logic [4:0] fl;
    logic [11:0] ix, t, m;
    op = (k % 3 == 0) ? OPC_INC : (k % 3 == 1) ? OPC_INC_SKZ : OPC_INC_SKNZ;
    {d, a, x} = 3'($urandom);
    b = 4'($urandom % 8);
    f = 8'($urandom);
    m0 = 8'($urandom % 128);
    fl = 5'($urandom);
    ix = 12'h800 | 12'($urandom % 256);
    s = v + 8'h01;
    t = a ? {b, f} : (x && f <= INDEX_LIMIT) ? ix + 12'(f) : (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HI_BANK, f};
    m = {b, f ^ 8'h80};
    skip = (op == OPC_INC_SKZ) ? (s == 8'h00) : (op == OPC_INC_SKNZ) && (s != 8'h00);
    i_mem.pm[0] = {op, d, a, f};
    i_mem.pm[1] = {OPC_INC_SKZ, 2'b11, f ^ 8'h80};
    i_mem.rf[t] = v;
    i_mem.rf[m] = m0;
    apb(1'b1, OFS_FLAGS, {23'h0, 1'b1, 3'h0, fl});
    apb(1'b1, OFS_ACC, {24'h0, ~s});
    apb(1'b1, OFS_INDEX, {20'h0, ix});
    run({20'h0, b, 6'h0, x, 1'b1}, 8);
    chk(i_mem.rf[t], d ? s : v);
    apb(1'b0, OFS_ACC, 32'h0);
    chk(rd[7:0], 8'(d ? ~s : s));
    chk(i_mem.rf[m], skip ? m0 : m0 + 8'h01);
    apb(1'b0, OFS_FLAGS, 32'h0);
    chk({rd[8], rd[4:0]}, {skip, (op == OPC_INC) ? iflags(v) : fl});
    $display("increment test %0d done", k);
  endtask

  // Far jump, optionally skipped by a leading skip-if-zero on 0xff.
  task automatic jump_test(input logic [19:0] k, input logic pre);
    i_mem.pm[0] = pre ? {OPC_INC_SKZ, 2'b11, 8'h01} : 16'h0000;
    i_mem.pm[1] = {OPC_JUMP_W1, k[7:0]};
    i_mem.pm[2] = {OPC_JUMP_W2, k[19:8]};
    i_mem.pm[3] = {OPC_INC_SKZ, 2'b11, 8'h03};
    i_mem.pm[k[7:0]] = {OPC_INC_SKZ, 2'b11, 8'h04};
    i_mem.rf[1] = 8'hff;
    i_mem.rf[3] = 8'h00;
    i_mem.rf[4] = 8'h00;
    jt = {k, 1'b0};
    seen = 1'b0;
    run(32'h1, 10);
    chk(i_mem.rf[3], pre);
    chk(i_mem.rf[4], !pre);
    chk(seen, !pre);
    $display("jump test %h done", k);
  endtask

  // Main sequence: reset values, increments, jumps.
  initial begin
    void'($urandom(32'h15e6));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (cv[i]) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
      // Only the sixth offset lies outside the map.
      chk({31'h0, err}, 32'(i == 5));
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("reset test done");
    for (int k = 0; k < 24; k++) begin
      inc_test(k, (k < 6) ? cv[k] : 8'($urandom));
    end
    jump_test(20'hfff7f, 1'b0);
    jump_test({12'($urandom), 8'h40 | 8'($urandom % 64)}, 1'b0);
    jump_test(20'h12345, 1'b1);
    tally_and_finish;
  end
endmodule
